// [rtl/dfs_pkg.sv]
// package: drive fault supervisor constants, register map and carrier types
package dfs_pkg;
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned TICK_S = 1;
   localparam int unsigned TICK_CYC = CLK_HZ * TICK_S;
   localparam int unsigned SAVE_S = 60;
   localparam logic [5:0] SAVE_TICKS = 6'(SAVE_S - 1);
   localparam logic [7:0] TEMP_WARN_DEG = 8'h05;
   localparam logic [7:0] MOT_PTC_LIMIT = 8'h8c;
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_FAULT = 12'h004;
   localparam logic [11:0] ADDR_WARN = 12'h008;
   localparam logic [11:0] ADDR_IMAX = 12'h00c;
   localparam logic [11:0] ADDR_IRATED = 12'h010;
   localparam logic [11:0] ADDR_I2T_MAX = 12'h014;
   localparam logic [11:0] ADDR_VDC_LIM = 12'h018;
   localparam logic [11:0] ADDR_VLOG_LIM = 12'h01c;
   localparam logic [11:0] ADDR_VINT_LIM = 12'h020;
   localparam logic [11:0] ADDR_TEMP_LIM = 12'h024;
   localparam logic [11:0] ADDR_FERR_LIM = 12'h028;
   localparam logic [11:0] ADDR_POS_MIN = 12'h02c;
   localparam logic [11:0] ADDR_POS_MAX = 12'h030;
   localparam logic [11:0] ADDR_OFS_TOL = 12'h034;
   localparam logic [11:0] ADDR_HOURS = 12'h038;
   localparam logic [11:0] ADDR_STATE = 12'h03c;
   localparam logic [11:0] ADDR_I2T_DRV = 12'h040;
   localparam logic [11:0] ADDR_I2T_MOT = 12'h044;
   // ctrl bit positions
   localparam int unsigned C_ACK = 0;
   localparam int unsigned C_WEN_DRV = 1;
   localparam int unsigned C_WEN_MOT = 2;
   localparam int unsigned C_WEN_TMP = 3;
   localparam int unsigned C_UV_LO = 4;
   localparam int unsigned C_MOT_PTC = 6;
   localparam logic [31:0] CTRL_RST = 32'h0000_000e;
   // fault bit positions
   localparam int unsigned F_OVC = 0;
   localparam int unsigned F_BRK = 1;
   localparam int unsigned F_OFS = 2;
   localparam int unsigned F_OVV = 3;
   localparam int unsigned F_UNV = 4;
   localparam int unsigned F_LOG = 5;
   localparam int unsigned F_INT = 6;
   localparam int unsigned F_TMP = 7;
   localparam int unsigned F_ENC = 8;
   localparam int unsigned F_MOT = 9;
   localparam int unsigned F_IDN = 10;
   localparam int unsigned F_FER = 11;
   localparam int unsigned F_POS = 12;
   localparam int unsigned F_LIM = 13;
   localparam int unsigned F_PRG = 14;
   localparam int unsigned F_MEM = 15;
   localparam int unsigned F_COM = 16;
   localparam int unsigned NFLT = 17;
   // faults that cut the stage at once; the rest, bar undervoltage in UV_CRIT mode, stop along the ramp first
   localparam logic [NFLT-1:0] CRIT_MASK = 17'h0_03ef;
   localparam int unsigned W_DRV = 0;
   localparam int unsigned W_MOT = 1;
   localparam int unsigned W_TMP = 2;
   localparam logic [1:0] UV_CRIT = 2'h0;
   localparam logic [1:0] UV_ERR = 2'h1;
   localparam logic [1:0] UV_WARN = 2'h2;
   localparam logic [1:0] UV_OFF = 2'h3;

   typedef enum logic [1:0] {ST_OFF, ST_CAL, ST_RUN, ST_RAMP} dfs_stage_type;

   typedef struct packed {
      logic [15:0] i_dc;
      logic [15:0] i_phase;
      logic [15:0] i_offset;
      logic [15:0] v_dc;
      logic [15:0] v_logic;
      logic [15:0] v_int;
      logic [7:0] t_sink;
      logic [7:0] t_motor;
      logic mot_contact_open;
      logic chopper_on;
      logic brake_short;
      logic enc_fault;
      logic ident_fail;
      logic [31:0] pos_cmd;
      logic [31:0] pos_act;
      logic pos_move;
      logic [1:0] limit_sw;
      logic prog_bad_cmd;
      logic flash_sum_bad;
      logic stack_bad;
      logic serial_fail;
      logic fbus_fail;
      logic enable_req;
      logic at_standstill;
      logic cal_done;
      logic [31:0] hours_saved;
   } dfs_meas_type;

   typedef struct packed {
      logic stage_on;
      logic quick_stop;
      logic cal_start;
      logic current_limit;
      logic [15:0] i_max_now;
      logic save_strobe;
      logic [31:0] save_value;
   } dfs_act_type;

   function automatic logic [31:0] dfs_sq(input logic [15:0] i);
      dfs_sq = 32'(i) * 32'(i);
   endfunction

   function automatic logic [31:0] dfs_i2t(input logic [31:0] acc, input logic [15:0] i,
                                          input logic [31:0] cap, input logic [15:0] rated);
      logic [32:0] s;
      s = 33'(acc) + 33'(dfs_sq(i));
      s = (s > 33'(dfs_sq(rated))) ? s - 33'(dfs_sq(rated)) : 33'h0;
      dfs_i2t = (s > 33'(cap)) ? cap : s[31:0];
   endfunction

   function automatic logic dfs_pct80(input logic [31:0] acc, input logic [31:0] cap);
      dfs_pct80 = (35'(acc) * 35'h5) >= (35'(cap) * 35'h4);
   endfunction
endpackage

// [rtl/dfs_top.sv]
// drive fault supervisor with axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none
module dfs_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire dfs_pkg::dfs_meas_type meas,
   output var dfs_pkg::dfs_act_type act
);
   import dfs_pkg::*;

   typedef struct packed {
      logic aw_got;
      logic w_got;
      logic [11:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [31:0] ctrl;
      logic [15:0] imax;
      logic [15:0] irated;
      logic [31:0] i2t_max;
      logic [31:0] vdc_lim;
      logic [31:0] vlog_lim;
      logic [31:0] vint_lim;
      logic [15:0] temp_lim;
      logic [31:0] ferr_lim;
      logic [31:0] pos_min;
      logic [31:0] pos_max;
      logic [15:0] ofs_tol;
      logic [NFLT-1:0] fault;
      logic [2:0] warn;
      logic [31:0] i2t_drv;
      logic [31:0] i2t_mot;
      dfs_stage_type stage;
      logic [24:0] tick_cnt;
      logic [5:0] sec_cnt;
      logic [31:0] hours;
      logic loaded;
      dfs_act_type act;
   } dfs_state_type;

   dfs_state_type s_r, s_nxt;

   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (st[b]) begin
            r[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      wmerge = r;
   endfunction

   logic [NFLT-1:0] cause;
   logic [NFLT-1:0] crit;
   logic [2:0] wcond;
   logic uv;
   logic [31:0] ferr;
   logic [7:0] tlim;
   logic mot_hot;
   logic do_wr;
   logic do_rd;
   logic wr_ok;
   logic [31:0] wv;

   always_comb begin
      s_nxt = s_r;
      cause = '0;
      wcond = '0;
      wr_ok = 1'b1;
      wv = 32'h0;
      // fault causes
      // overcurrent detect
      cause[F_OVC] = 17'(meas.i_dc) > (17'(s_r.imax) << 1);
      cause[F_BRK] = meas.chopper_on & meas.brake_short;
      cause[F_OVV] = meas.v_dc > s_r.vdc_lim[31:16];
      uv = meas.v_dc < s_r.vdc_lim[15:0];
      cause[F_UNV] = uv & (s_r.ctrl[C_UV_LO +: 2] inside {UV_CRIT, UV_ERR});
      crit = CRIT_MASK;
      crit[F_UNV] = s_r.ctrl[C_UV_LO +: 2] == UV_CRIT;
      cause[F_LOG] = (meas.v_logic > s_r.vlog_lim[31:16]) | (meas.v_logic < s_r.vlog_lim[15:0]);
      cause[F_INT] = (meas.v_int > s_r.vint_lim[31:16]) | (meas.v_int < s_r.vint_lim[15:0]);
      cause[F_TMP] = meas.t_sink >= s_r.temp_lim[7:0];
      cause[F_ENC] = meas.enc_fault;
      tlim = s_r.ctrl[C_MOT_PTC] ? MOT_PTC_LIMIT : s_r.temp_lim[15:8];
      mot_hot = s_r.ctrl[C_MOT_PTC] ? meas.mot_contact_open : (meas.t_motor >= tlim);
      cause[F_MOT] = mot_hot;
      cause[F_IDN] = meas.ident_fail;
      ferr = ($signed(meas.pos_cmd) >= $signed(meas.pos_act)) ?
             meas.pos_cmd - meas.pos_act : meas.pos_act - meas.pos_cmd;
      cause[F_FER] = ferr > s_r.ferr_lim;
      cause[F_POS] = meas.pos_move & (($signed(meas.pos_cmd) < $signed(s_r.pos_min)) |
                     ($signed(meas.pos_cmd) > $signed(s_r.pos_max)) |
                     ($signed(meas.pos_act) < $signed(s_r.pos_min)) |
                     ($signed(meas.pos_act) > $signed(s_r.pos_max)));
      cause[F_LIM] = &meas.limit_sw;
      cause[F_PRG] = meas.prog_bad_cmd;
      cause[F_MEM] = meas.flash_sum_bad | meas.stack_bad;
      cause[F_COM] = meas.serial_fail | meas.fbus_fail;
      cause[F_OFS] = (s_r.stage == ST_CAL) & meas.cal_done &
                     (meas.i_offset > s_r.ofs_tol);

      s_nxt.i2t_drv = dfs_i2t(s_r.i2t_drv, meas.i_phase, s_r.i2t_max, s_r.irated);
      s_nxt.i2t_mot = dfs_i2t(s_r.i2t_mot, meas.i_phase, s_r.i2t_max, {1'b0, s_r.irated[15:1]});
      wcond[W_DRV] = s_r.ctrl[C_WEN_DRV] & dfs_pct80(s_r.i2t_drv, s_r.i2t_max);
      wcond[W_MOT] = s_r.ctrl[C_WEN_MOT] & dfs_pct80(s_r.i2t_mot, s_r.i2t_max);
      wcond[W_TMP] = s_r.ctrl[C_WEN_TMP] & (9'(meas.t_sink) + 9'(TEMP_WARN_DEG) >=
                     9'(s_r.temp_lim[7:0]));
      s_nxt.warn = wcond;
      s_nxt.act.current_limit = (s_r.i2t_drv >= s_r.i2t_max) | (s_r.i2t_mot >= s_r.i2t_max);
      s_nxt.act.i_max_now = s_nxt.act.current_limit ? s_r.irated : s_r.imax;

      // axi write channel
      if (s_axi_awvalid && !s_r.aw_got) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_r.w_got) begin
         s_nxt.w_got = 1'b1;
         s_nxt.wdata = s_axi_wdata;
         s_nxt.wstrb = s_axi_wstrb;
      end
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end
      do_wr = s_r.aw_got & s_r.w_got & ~s_r.bvalid;
      s_nxt.fault = s_r.fault;
      if (do_wr) begin
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
         s_nxt.bvalid = 1'b1;
         unique case (s_r.awaddr)
            ADDR_CTRL: begin
               wv = wmerge(s_r.ctrl, s_r.wdata, s_r.wstrb);
               s_nxt.ctrl = wv & ~(32'h1 << C_ACK);
               if (wv[C_ACK]) begin
                  s_nxt.fault = '0;
               end
            end
            ADDR_IMAX: s_nxt.imax = 16'(wmerge({16'h0, s_r.imax}, s_r.wdata, s_r.wstrb));
            ADDR_IRATED: s_nxt.irated = 16'(wmerge({16'h0, s_r.irated}, s_r.wdata, s_r.wstrb));
            ADDR_I2T_MAX: s_nxt.i2t_max = wmerge(s_r.i2t_max, s_r.wdata, s_r.wstrb);
            ADDR_VDC_LIM: s_nxt.vdc_lim = wmerge(s_r.vdc_lim, s_r.wdata, s_r.wstrb);
            ADDR_VLOG_LIM: s_nxt.vlog_lim = wmerge(s_r.vlog_lim, s_r.wdata, s_r.wstrb);
            ADDR_VINT_LIM: s_nxt.vint_lim = wmerge(s_r.vint_lim, s_r.wdata, s_r.wstrb);
            ADDR_TEMP_LIM: s_nxt.temp_lim = 16'(wmerge({16'h0, s_r.temp_lim}, s_r.wdata,
                                                   s_r.wstrb));
            ADDR_FERR_LIM: s_nxt.ferr_lim = wmerge(s_r.ferr_lim, s_r.wdata, s_r.wstrb);
            ADDR_POS_MIN: s_nxt.pos_min = wmerge(s_r.pos_min, s_r.wdata, s_r.wstrb);
            ADDR_POS_MAX: s_nxt.pos_max = wmerge(s_r.pos_max, s_r.wdata, s_r.wstrb);
            ADDR_OFS_TOL: s_nxt.ofs_tol = 16'(wmerge({16'h0, s_r.ofs_tol}, s_r.wdata,
                                                 s_r.wstrb));
            ADDR_FAULT, ADDR_WARN, ADDR_HOURS, ADDR_STATE, ADDR_I2T_DRV, ADDR_I2T_MOT: ;
            default: wr_ok = 1'b0;
         endcase
         s_nxt.bresp = wr_ok ? 2'h0 : 2'h2;
      end
      // set wins over acknowledge
      s_nxt.fault = s_nxt.fault | cause;

      // axi read channel
      do_rd = s_axi_arvalid & ~s_r.rvalid;
      if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (do_rd) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = 2'h0;
         unique case (s_axi_araddr)
            ADDR_CTRL: s_nxt.rdata = s_r.ctrl;
            ADDR_FAULT: s_nxt.rdata = 32'(s_r.fault);
            ADDR_WARN: s_nxt.rdata = 32'(s_r.warn);
            ADDR_IMAX: s_nxt.rdata = 32'(s_r.imax);
            ADDR_IRATED: s_nxt.rdata = 32'(s_r.irated);
            ADDR_I2T_MAX: s_nxt.rdata = s_r.i2t_max;
            ADDR_VDC_LIM: s_nxt.rdata = s_r.vdc_lim;
            ADDR_VLOG_LIM: s_nxt.rdata = s_r.vlog_lim;
            ADDR_VINT_LIM: s_nxt.rdata = s_r.vint_lim;
            ADDR_TEMP_LIM: s_nxt.rdata = 32'(s_r.temp_lim);
            ADDR_FERR_LIM: s_nxt.rdata = s_r.ferr_lim;
            ADDR_POS_MIN: s_nxt.rdata = s_r.pos_min;
            ADDR_POS_MAX: s_nxt.rdata = s_r.pos_max;
            ADDR_OFS_TOL: s_nxt.rdata = 32'(s_r.ofs_tol);
            ADDR_HOURS: s_nxt.rdata = s_r.hours;
            ADDR_STATE: s_nxt.rdata = {27'h0, s_r.act.current_limit, s_r.act.stage_on,
                                       s_r.act.quick_stop, s_r.stage};
            ADDR_I2T_DRV: s_nxt.rdata = s_r.i2t_drv;
            ADDR_I2T_MOT: s_nxt.rdata = s_r.i2t_mot;
            default: begin
               s_nxt.rdata = 32'h0;
               s_nxt.rresp = 2'h2;
            end
         endcase
      end

      s_nxt.act.cal_start = 1'b0;
      unique case (s_r.stage)
         ST_OFF: begin
            if (meas.enable_req && s_r.fault == '0 && cause == '0) begin
               s_nxt.stage = ST_CAL;
               s_nxt.act.cal_start = 1'b1;
            end
         end
         ST_CAL: begin
            if ((s_nxt.fault & crit) != '0 || !meas.enable_req) begin
               s_nxt.stage = ST_OFF;
            end else if (meas.cal_done) begin
               s_nxt.stage = (s_nxt.fault != '0) ? ST_OFF : ST_RUN;
            end
         end
         ST_RUN: begin
            if ((s_nxt.fault & crit) != '0 || !meas.enable_req) begin
               s_nxt.stage = ST_OFF;
            end else if (s_nxt.fault != '0) begin
               s_nxt.stage = ST_RAMP;
            end
         end
         ST_RAMP: begin
            if ((s_nxt.fault & crit) != '0 || meas.at_standstill) begin
               s_nxt.stage = ST_OFF;
            end
         end
      endcase
      s_nxt.act.stage_on = (s_nxt.stage == ST_RUN) | (s_nxt.stage == ST_RAMP);
      s_nxt.act.quick_stop = s_nxt.stage == ST_RAMP;

      s_nxt.act.save_strobe = 1'b0;
      if (!s_r.loaded) begin
         s_nxt.loaded = 1'b1;
         s_nxt.hours = meas.hours_saved;
      end else if (s_r.tick_cnt == 25'(TICK_CYC - 1)) begin
         s_nxt.tick_cnt = '0;
         s_nxt.hours = s_r.hours + 32'h1;
         if (s_r.sec_cnt == SAVE_TICKS) begin
            s_nxt.sec_cnt = '0;
            s_nxt.act.save_strobe = 1'b1;
            s_nxt.act.save_value = s_r.hours + 32'h1;
         end else begin
            s_nxt.sec_cnt = s_r.sec_cnt + 6'h1;
         end
      end else begin
         s_nxt.tick_cnt = s_r.tick_cnt + 25'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
         s_r.ctrl <= CTRL_RST;
         s_r.stage <= ST_OFF;
         s_r.imax <= 16'hffff;
         s_r.irated <= 16'hffff;
         s_r.i2t_max <= 32'hffff_ffff;
         s_r.vdc_lim <= 32'hffff_0000;
         s_r.vlog_lim <= 32'hffff_0000;
         s_r.vint_lim <= 32'hffff_0000;
         s_r.temp_lim <= 16'hffff;
         s_r.ferr_lim <= 32'hffff_ffff;
         s_r.pos_min <= 32'h8000_0000;
         s_r.pos_max <= 32'h7fff_ffff;
         s_r.ofs_tol <= 16'hffff;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign s_axi_awready = ~s_r.aw_got;
   assign s_axi_wready = ~s_r.w_got;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_arready = ~s_r.rvalid;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rresp = s_r.rresp;
   assign s_axi_rdata = s_r.rdata;
   assign act = s_r.act;

   ovc_cut_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (17'(meas.i_dc) > (17'(s_r.imax) << 1)) |=> !act.stage_on && s_r.fault[F_OVC])
      else $error("overcurrent did not cut stage");
   brk_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (meas.chopper_on && meas.brake_short) |=> s_r.fault[F_BRK])
      else $error("brake short not flagged");
   ovv_cut_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (meas.v_dc > s_r.vdc_lim[31:16]) |=> !act.stage_on)
      else $error("overvoltage did not cut stage");
   restart_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_r.fault != '0 && s_r.stage == ST_OFF) |=> s_r.stage == ST_OFF)
      else $error("stage restarted with latched fault");
   lim_sw_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (&meas.limit_sw) |=> s_r.fault[F_LIM])
      else $error("double limit switch missed");
   warn_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (9'(meas.t_sink) + 9'(TEMP_WARN_DEG) < 9'(s_r.temp_lim[7:0])) |=> !s_r.warn[W_TMP])
      else $error("sink warning did not clear");
   warn_no_cut_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_r.stage == ST_RUN && meas.enable_req && cause == '0 && s_r.fault == '0) |=> act.stage_on)
      else $error("warning affected stage");
   uv_crit_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_r.ctrl[C_UV_LO +: 2] == UV_CRIT && meas.v_dc < s_r.vdc_lim[15:0]) |=> !act.stage_on)
      else $error("critical undervoltage did not cut stage");
   clamp_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_r.i2t_drv >= s_r.i2t_max) |=> act.current_limit ##0 act.i_max_now == $past(s_r.irated))
      else $error("i2t clamp missing");
   ramp_then_cut_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_r.stage == ST_RAMP && meas.at_standstill) |=> !act.stage_on && !act.quick_stop)
      else $error("ramp did not end in cut");
   save_min_a: assert property (@(posedge aclk) disable iff (!aresetn)
      act.save_strobe |-> act.save_value == s_r.hours)
      else $error("saved value differs from count");
   enc_cut_a: assert property (@(posedge aclk) disable iff (!aresetn)
      meas.enc_fault |=> !act.stage_on [*2])
      else $error("encoder fault did not cut stage");
endmodule
`default_nettype wire

// [sim/dfs_plant.sv]
// partner model: power stage and sensors answering the supervisor
`timescale 1ns/1ps
`default_nettype none
module dfs_plant
   import dfs_pkg::*;
(
   input wire logic aclk,
   input wire dfs_pkg::dfs_act_type act,
   input wire dfs_pkg::dfs_meas_type kn,
   output var dfs_pkg::dfs_meas_type meas
);
   logic [2:0] cal_r = 3'h0;
   always_ff @(posedge aclk) begin
      cal_r <= {cal_r[1:0], act.cal_start};
   end
   always_comb begin
      meas = kn;
      meas.cal_done = cal_r[2];
   end
endmodule
`default_nettype wire

// [sim/dfs_top_tb.sv]
// testbench: axi4-lite sequences against the drive fault supervisor
`timescale 1ns/1ps
`default_nettype none
module dfs_top_tb;
   import dfs_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [31:0] s_axi_rdata, d;
   dfs_meas_type kn, meas;
   dfs_act_type act;
   int n_fail = 0;
   int cmp_count = 0;
   int fb[13] = '{F_OVC, F_BRK, F_OVV, F_ENC, F_LIM, F_PRG, F_COM, F_IDN, F_MEM,
                  F_LOG, F_INT, F_FER, F_POS};
   logic crit;
   initial begin
      forever #25 aclk = ~aclk;
   end
   dfs_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .meas, .act);
   dfs_plant plant_u (.aclk, .act, .kn, .meas);
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rd(input logic [11:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      rd(a);
      chk(d, e);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         aw = aw | s_axi_awready;
         w = w | s_axi_wready;
         s_axi_awvalid <= !aw;
         s_axi_wvalid <= !w;
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      r = s_axi_bresp;
   endtask
   task automatic up();
      kn.enable_req <= 1'b1;
      for (int i = 0; i < 60 && !act.stage_on; i++) @(posedge aclk);
      chk(act.stage_on, 1'b1);
   endtask
   task automatic inj(input int k, input logic v);
      case (k)
         0: kn.i_dc <= v ? 16'h0300 : 16'h0010;
         1: kn.brake_short <= v;
         2: kn.v_dc <= v ? 16'h0500 : 16'h0200;
         3: kn.enc_fault <= v;
         4: kn.limit_sw <= {v, v};
         5: kn.prog_bad_cmd <= v;
         6: kn.serial_fail <= v;
         7: kn.ident_fail <= v;
         8: kn.flash_sum_bad <= v;
         9: kn.v_logic <= v ? 16'h0050 : 16'h0200;
         10: kn.v_int <= v ? 16'h0400 : 16'h0200;
         11: kn.pos_cmd <= v ? 32'h0000_0200 : 32'h0;
         default: begin
            kn.pos_move <= v;
            kn.pos_cmd <= v ? 32'h0000_2000 : 32'h0;
            kn.pos_act <= v ? 32'h0000_2000 : 32'h0;
         end
      endcase
   endtask
   task automatic conclude();
      $display("counts: %0d compares, %0d mismatches", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      #1000000;
      n_fail++;
      conclude();
   end
   initial begin
      kn = '0;
      kn.v_dc = 16'h0200;
      kn.i_dc = 16'h0010;
      kn.t_sink = 8'h20;
      kn.v_logic = 16'h0200;
      kn.v_int = 16'h0200;
      kn.chopper_on = 1'b1;
      kn.hours_saved = 32'h0000_1234;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rdc(ADDR_CTRL, CTRL_RST);
      rdc(ADDR_HOURS, 32'h0000_1234);
      rd(12'h100);
      chk(32'(r), 32'h2);
      wr(ADDR_IMAX, 32'h0000_0100);
      wr(ADDR_VDC_LIM, 32'h0400_0100);
      wr(ADDR_VLOG_LIM, 32'h0300_0100);
      wr(ADDR_VINT_LIM, 32'h0300_0100);
      wr(ADDR_FERR_LIM, 32'h0000_0100);
      wr(ADDR_POS_MAX, 32'h0000_1000);
      $display("test reset done");
      for (int k = 0; k < 13; k++) begin
         crit = CRIT_MASK[fb[k]];
         up();
         inj(k, 1'b1);
         repeat (3) @(posedge aclk);
         chk({act.stage_on, act.quick_stop}, crit ? 32'h0 : 32'h3);
         kn.at_standstill <= 1'b1;
         kn.enable_req <= 1'b0;
         repeat (4) @(posedge aclk);
         chk(act.stage_on, 1'b0);
         wr(ADDR_CTRL, 32'h0000_000f);
         rdc(ADDR_FAULT, 32'(1) << fb[k]);
         inj(k, 1'b0);
         kn.enable_req <= 1'b1;
         repeat (8) @(posedge aclk);
         chk(act.stage_on, 1'b0);
         kn.enable_req <= 1'b0;
         kn.at_standstill <= 1'b0;
         wr(ADDR_CTRL, 32'h0000_000f);
         rdc(ADDR_FAULT, 32'h0);
      end
      wr(ADDR_OFS_TOL, 32'h0000_0040);
      kn.i_offset <= 16'h0080;
      kn.enable_req <= 1'b1;
      repeat (8) @(posedge aclk);
      chk(act.stage_on, 1'b0);
      kn.enable_req <= 1'b0;
      kn.i_offset <= 16'h0000;
      rdc(ADDR_FAULT, 32'h4);
      wr(ADDR_CTRL, 32'h0000_000f);
      $display("test faults done");
      for (int m = 0; m < 4; m++) begin
         wr(ADDR_CTRL, 32'(m * 16 + 14));
         up();
         kn.v_dc <= 16'h0050;
         repeat (3) @(posedge aclk);
         chk({act.stage_on, act.quick_stop}, (m == 0) ? 32'h0 : (m == 1) ? 32'h3 : 32'h2);
         kn.v_dc <= 16'h0200;
         kn.enable_req <= 1'b0;
         kn.at_standstill <= 1'b1;
         repeat (4) @(posedge aclk);
         rdc(ADDR_FAULT, (m < 2) ? 32'h10 : 32'h0);
         kn.at_standstill <= 1'b0;
         wr(ADDR_CTRL, 32'(m * 16 + 15));
      end
      $display("test undervoltage done");
      wr(ADDR_IRATED, 32'h0000_0010);
      wr(ADDR_I2T_MAX, 32'h0000_1000);
      kn.i_phase <= 16'h0020;
      repeat (20) @(posedge aclk);
      rdc(ADDR_WARN, 32'h3);
      chk({act.current_limit, act.i_max_now}, 32'h1_0010);
      wr(ADDR_CTRL, 32'h0000_003c);
      rdc(ADDR_WARN, 32'h2);
      kn.i_phase <= 16'h0000;
      repeat (100) @(posedge aclk);
      rdc(ADDR_WARN, 32'h0);
      chk(act.current_limit, 1'b0);
      $display("test i2t done");
      wr(ADDR_TEMP_LIM, 32'h0000_9050);
      kn.t_sink <= 8'h4e;
      repeat (3) @(posedge aclk);
      rdc(ADDR_WARN, 32'h4);
      kn.t_sink <= 8'h50;
      kn.t_motor <= 8'h90;
      repeat (3) @(posedge aclk);
      rdc(ADDR_FAULT, 32'h280);
      kn.t_sink <= 8'h20;
      kn.t_motor <= 8'h00;
      wr(ADDR_CTRL, 32'h0000_007d);
      kn.mot_contact_open <= 1'b1;
      repeat (3) @(posedge aclk);
      rdc(ADDR_FAULT, 32'h200);
      $display("test temperature done");
      conclude();
   end
endmodule
`default_nettype wire
